// *** core/cstr_pkg.sv ***
// package: constants and carrier types for the trigger routing crossbar
package cstr_pkg;

  // clock and timing
  localparam int CSTR_CLK_MHZ = 10;
  localparam int CSTR_RESYNC_PERIOD_MS = 100;
  localparam int CSTR_RESYNC_HALF_CYC =
    CSTR_RESYNC_PERIOD_MS * CSTR_CLK_MHZ * 1000 / 2;
  localparam int CSTR_BIT_TIME_NS = 1000;
  localparam int CSTR_BIT_CYC_RAW = CSTR_BIT_TIME_NS * CSTR_CLK_MHZ / 1000;
  localparam int CSTR_BIT_CYC = (CSTR_BIT_CYC_RAW < 1) ? 1 : CSTR_BIT_CYC_RAW;
  localparam int CSTR_NUM_LINES = 7;
  localparam int CSTR_STAR_MIN_SLOT = 3;

  // register byte offsets
  localparam logic [7:0] CSTR_OFS_ROUTE = 8'h00;
  localparam logic [7:0] CSTR_OFS_CONTROL = 8'h04;
  localparam logic [7:0] CSTR_OFS_CONFIG = 8'h08;
  localparam logic [7:0] CSTR_OFS_STATUS = 8'h0C;
  localparam logic [7:0] CSTR_OFS_GP_MAP = 8'h10;
  localparam logic [7:0] CSTR_OFS_CLK_MAP = 8'h14;

  // field positions
  localparam int CSTR_CTL_START_BIT = 0;
  localparam int CSTR_CTL_CLEAR_BIT = 1;

  // source terminal codes
  localparam logic [3:0] CSTR_SRC_LINE_MAX = 4'h6;
  localparam logic [3:0] CSTR_SRC_TB_LINE = 4'h7;
  localparam logic [3:0] CSTR_SRC_STAR = 4'h8;
  localparam logic [3:0] CSTR_SRC_BP10 = 4'h9;
  localparam logic [3:0] CSTR_SRC_LOCAL_OSC = 4'hA;
  localparam logic [3:0] CSTR_SRC_RESYNC = 4'hB;
  localparam logic [3:0] CSTR_SRC_FRAME_ACC = 4'hC;
  localparam logic [3:0] CSTR_SRC_FAULT = 4'hD;
  localparam logic [3:0] CSTR_SRC_START = 4'hE;
  localparam logic [3:0] CSTR_SRC_NONE = 4'hF;

  // destination terminal codes
  localparam logic [3:0] CSTR_DST_LINE_MAX = 4'h6;
  localparam logic [3:0] CSTR_DST_TB_LINE = 4'h7;
  localparam logic [3:0] CSTR_DST_MASTER_TB = 4'h8;
  localparam logic [3:0] CSTR_DST_RESYNC_IN = 4'h9;
  localparam logic [3:0] CSTR_DST_START_SEL = 4'hA;

  // form factors, master timebase selections, error codes
  localparam logic [1:0] CSTR_FF_PCI = 2'h0;
  localparam logic [1:0] CSTR_FF_PXI = 2'h1;
  localparam logic [1:0] CSTR_FF_PCMCIA = 2'h2;
  localparam logic [1:0] CSTR_MTB_LOCAL = 2'h0;
  localparam logic [1:0] CSTR_MTB_TB_LINE = 2'h1;
  localparam logic [1:0] CSTR_MTB_BP10 = 2'h2;
  localparam logic [1:0] CSTR_ERR_NONE = 2'h0;
  localparam logic [1:0] CSTR_ERR_PAIR = 2'h1;
  localparam logic [1:0] CSTR_ERR_HW = 2'h2;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cstr_bus_req_t;

  // route command word, low bits of a route write
  typedef struct packed {
    logic connect;
    logic [3:0] dst;
    logic [3:0] src;
  } cstr_cmd_t;

  // board configuration
  typedef struct packed {
    logic gen2;
    logic [1:0] form;
    logic [4:0] slot;
  } cstr_cfg_t;

  localparam cstr_cfg_t CSTR_CFG_RESET = '{gen2: 1'b1, form: CSTR_FF_PCI,
                                          slot: 5'h00};

endpackage

// *** core/cstr_routing.sv ***
// module: trigger bus routing and synchronisation crossbar of the card
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module cstr_routing import cstr_pkg::*; #(
  parameter int RESYNC_HALF = CSTR_RESYNC_HALF_CYC,
  parameter int BIT_CYCLES = CSTR_BIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cstr_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic [6:0] trig_line_in,
  output logic [6:0] trig_line_out,
  output logic [6:0] trig_line_oe,
  input wire logic star_trigger_input,
  input wire logic transceiver_fault_n,
  input wire logic rx_eof_last_bit,
  input wire logic rx_filter_pass,
  output logic timebase_line_oe,
  output logic [1:0] master_timebase_sel,
  output logic resync_clock_output,
  output logic timebase_realign,
  output logic frame_accepted_pulse,
  output logic sampling_start,
  output logic sampling_started,
  output logic can_controller_run
);

  // refuse settings the counters cannot hold
  if (RESYNC_HALF < 2 || RESYNC_HALF > 1048576) begin : g_chk_rs
    $error("resync half period out of range");
  end
  if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_chk_bit
    $error("bit time cycles out of range");
  end

  // whole state of the block
  typedef struct packed {
    cstr_cfg_t cfg;                       // board configuration
    logic [6:0][3:0] gp_src;              // source per trigger line
    logic tb_out_en;                      // oscillator onto line 7
    logic [1:0] mtb_sel;                  // master timebase choice
    logic [3:0] rs_src;                   // resync input line
    logic [3:0] st_src;                   // start trigger source
    logic [3:0] task_cnt;                 // running tasks
    logic armed;                          // waiting for start event
    logic started;                        // start trigger has fired
    logic start_pulse;                    // one-cycle start event
    logic [1:0] err;                      // result of last route write
    logic [31:0] rdata;                   // read answer
    logic [8:0] sync1;                    // first synchroniser stage
    logic [8:0] sync2;                    // second synchroniser stage
    logic [8:0] prev;                     // delayed copy for edges
    logic [19:0] rs_cnt;                  // resync half period count
    logic rs_wave;                        // resync square wave
    logic realign;                        // realign pulse
    logic [7:0] bit_cnt;                  // frame pulse length count
    logic fa_out;                         // frame accepted output
    logic [6:0] gp_out;                   // registered line levels
    logic [6:0] gp_oe;                    // registered line enables
  } cstr_st_t;

  cstr_st_t st_ff;
  cstr_st_t nxt_st;

  // legality of a route command, zero when accepted
  function automatic logic [1:0] route_err(cstr_cmd_t c, cstr_cfg_t g);
    logic [1:0] e;
    e = CSTR_ERR_PAIR;
    if (!c.connect) begin
      // disconnect: any known destination
      if (c.dst <= CSTR_DST_START_SEL) e = CSTR_ERR_NONE;
    end else if (c.dst <= CSTR_DST_LINE_MAX) begin
      // internal events onto lines, never oscillator
      if (c.src == CSTR_SRC_RESYNC || c.src == CSTR_SRC_START ||
          c.src == CSTR_SRC_FAULT) begin
        e = CSTR_ERR_NONE;
      end else if (c.src == CSTR_SRC_FRAME_ACC) begin
        e = g.gen2 ? CSTR_ERR_NONE : CSTR_ERR_HW;
      end
    end else if (c.dst == CSTR_DST_TB_LINE) begin
      // only the oscillator export, gen2 pci/pxi
      if (c.src == CSTR_SRC_LOCAL_OSC) begin
        e = (g.gen2 && g.form != CSTR_FF_PCMCIA) ? CSTR_ERR_NONE
                                                 : CSTR_ERR_HW;
      end
    end else if (c.dst == CSTR_DST_MASTER_TB) begin
      if (c.src == CSTR_SRC_TB_LINE) begin
        e = g.gen2 ? CSTR_ERR_NONE : CSTR_ERR_HW;
      end else if (c.src == CSTR_SRC_BP10) begin
        e = (g.gen2 && g.form == CSTR_FF_PXI) ? CSTR_ERR_NONE
                                              : CSTR_ERR_HW;
      end
    end else if (c.dst == CSTR_DST_RESYNC_IN) begin
      if (c.src <= CSTR_SRC_LINE_MAX) e = CSTR_ERR_NONE;
    end else if (c.dst == CSTR_DST_START_SEL) begin
      if (c.src <= CSTR_SRC_LINE_MAX) begin
        e = CSTR_ERR_NONE;
      end else if (c.src == CSTR_SRC_STAR) begin
        // star only on gen2 pxi in slot 3 or above
        e = (g.gen2 && g.form == CSTR_FF_PXI &&
             g.slot >= 5'(CSTR_STAR_MIN_SLOT)) ? CSTR_ERR_NONE
                                               : CSTR_ERR_HW;
      end
    end
    return e;
  endfunction

  // rising edge of a selected input terminal
  function automatic logic src_rise(logic [3:0] s, logic [8:0] rise);
    logic r;
    r = 1'b0;
    if (s <= CSTR_SRC_LINE_MAX) begin
      r = rise[s[2:0]];
    end else if (s == CSTR_SRC_STAR) begin
      r = rise[7];
    end
    return r;
  endfunction

  logic [8:0] rise;                       // edges of synced inputs
  cstr_cmd_t cmd;                         // route command view
  logic [3:0] cnt_after;                  // task count after control

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    cmd = bus_req.wdata[8:0];
    cnt_after = st_ff.task_cnt;
    // pins pass two flops; only the second stage is looked at
    nxt_st.sync1 = {transceiver_fault_n, star_trigger_input, trig_line_in};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    rise = st_ff.sync2 & ~st_ff.prev;
    nxt_st.start_pulse = 1'b0;
    nxt_st.realign = 1'b0;
    nxt_st.rdata = 32'h0000_0000;

    // free running resync square wave, equal halves
    if (st_ff.rs_cnt == 20'(RESYNC_HALF - 1)) begin
      nxt_st.rs_cnt = 20'h0_0000;
      nxt_st.rs_wave = ~st_ff.rs_wave;
    end else begin
      nxt_st.rs_cnt = st_ff.rs_cnt + 20'h0_0001;
    end

    // realign on each rise of the routed resync line
    if (st_ff.rs_src != CSTR_SRC_NONE && src_rise(st_ff.rs_src, rise)) begin
      nxt_st.realign = 1'b1;
    end

    // frame accepted: one bit time from last end-of-frame bit
    if (rx_eof_last_bit && rx_filter_pass) begin
      nxt_st.bit_cnt = 8'(BIT_CYCLES);
      nxt_st.fa_out = 1'b1;
    end else if (st_ff.bit_cnt > 8'h01) begin
      nxt_st.bit_cnt = st_ff.bit_cnt - 8'h01;
    end else begin
      nxt_st.bit_cnt = 8'h00;
      nxt_st.fa_out = 1'b0;
    end

    // routed start fires once on the first rise
    if (st_ff.armed && st_ff.st_src != CSTR_SRC_NONE &&
        src_rise(st_ff.st_src, rise)) begin
      nxt_st.armed = 1'b0;
      nxt_st.started = 1'b1;
      nxt_st.start_pulse = 1'b1;
    end

    // register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        CSTR_OFS_ROUTE: begin
          nxt_st.err = route_err(cmd, st_ff.cfg);
          // a refused command leaves every route as it was
          if (route_err(cmd, st_ff.cfg) == CSTR_ERR_NONE) begin
            if (cmd.dst <= CSTR_DST_LINE_MAX) begin
              nxt_st.gp_src[cmd.dst[2:0]] =
                cmd.connect ? cmd.src : CSTR_SRC_NONE;
            end else if (cmd.dst == CSTR_DST_TB_LINE) begin
              nxt_st.tb_out_en = cmd.connect;
            end else if (cmd.dst == CSTR_DST_MASTER_TB) begin
              if (!cmd.connect) begin
                nxt_st.mtb_sel = CSTR_MTB_LOCAL;
              end else if (cmd.src == CSTR_SRC_BP10) begin
                nxt_st.mtb_sel = CSTR_MTB_BP10;
              end else begin
                nxt_st.mtb_sel = CSTR_MTB_TB_LINE;
              end
            end else if (cmd.dst == CSTR_DST_RESYNC_IN) begin
              nxt_st.rs_src = cmd.connect ? cmd.src : CSTR_SRC_NONE;
            end else begin
              nxt_st.st_src = cmd.connect ? cmd.src : CSTR_SRC_NONE;
            end
          end
        end
        CSTR_OFS_CONTROL: begin
          // task start then task clear; count saturates both ways
          if (bus_req.wdata[CSTR_CTL_START_BIT] && cnt_after != 4'hF) begin
            cnt_after = cnt_after + 4'h1;
          end
          if (bus_req.wdata[CSTR_CTL_CLEAR_BIT] && cnt_after != 4'h0) begin
            cnt_after = cnt_after - 4'h1;
          end
          nxt_st.task_cnt = cnt_after;
          if (st_ff.task_cnt == 4'h0 && cnt_after != 4'h0) begin
            // communication begins: unrouted start fires now
            if (st_ff.st_src == CSTR_SRC_NONE) begin
              nxt_st.started = 1'b1;
              nxt_st.start_pulse = 1'b1;
              nxt_st.armed = 1'b0;
            end else begin
              nxt_st.armed = 1'b1;
            end
          end else if (st_ff.task_cnt != 4'h0 && cnt_after == 4'h0) begin
            // last task gone: halt and drop every connection
            nxt_st.gp_src = {CSTR_NUM_LINES{CSTR_SRC_NONE}};
            nxt_st.tb_out_en = 1'b0;
            nxt_st.mtb_sel = CSTR_MTB_LOCAL;
            nxt_st.rs_src = CSTR_SRC_NONE;
            nxt_st.st_src = CSTR_SRC_NONE;
            nxt_st.armed = 1'b0;
            nxt_st.started = 1'b0;
            nxt_st.start_pulse = 1'b0;
          end
        end
        CSTR_OFS_CONFIG: begin
          nxt_st.cfg = bus_req.wdata[7:0];
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end

    // register reads, answer stands in the next cycle only
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CSTR_OFS_CONFIG: nxt_st.rdata = {24'h00_0000, st_ff.cfg};
        CSTR_OFS_STATUS: begin
          nxt_st.rdata = {9'h000, st_ff.sync2, st_ff.err, st_ff.rs_wave,
                          st_ff.fa_out, st_ff.started, st_ff.armed,
                          st_ff.task_cnt, 4'h0};
        end
        CSTR_OFS_GP_MAP: nxt_st.rdata = {4'h0, st_ff.gp_src};
        CSTR_OFS_CLK_MAP: begin
          nxt_st.rdata = {21'h00_0000, st_ff.tb_out_en, st_ff.mtb_sel,
                          st_ff.rs_src, st_ff.st_src};
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // drive routed lines from flops; line 7 never used here
    for (int i = 0; i < CSTR_NUM_LINES; i++) begin
      nxt_st.gp_oe[i] = (st_ff.gp_src[i] != CSTR_SRC_NONE);
      unique case (st_ff.gp_src[i])
        CSTR_SRC_RESYNC: nxt_st.gp_out[i] = st_ff.rs_wave;
        CSTR_SRC_FRAME_ACC: nxt_st.gp_out[i] = st_ff.fa_out;
        CSTR_SRC_FAULT: nxt_st.gp_out[i] = st_ff.sync2[8];
        CSTR_SRC_START: nxt_st.gp_out[i] = st_ff.started;
        default: nxt_st.gp_out[i] = 1'b0;
      endcase
    end
  end

  // single register bank; reset gives an unrouted idle card
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.cfg <= CSTR_CFG_RESET;
      st_ff.gp_src <= {CSTR_NUM_LINES{CSTR_SRC_NONE}};
      st_ff.mtb_sel <= CSTR_MTB_LOCAL;
      st_ff.rs_src <= CSTR_SRC_NONE;
      st_ff.st_src <= CSTR_SRC_NONE;
      st_ff.sync1 <= 9'h1FF;
      st_ff.sync2 <= 9'h1FF;
      st_ff.prev <= 9'h1FF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs; clock selections are shared by both ports
  assign bus_rdata = st_ff.rdata;
  assign trig_line_out = st_ff.gp_out;
  assign trig_line_oe = st_ff.gp_oe;
  assign timebase_line_oe = st_ff.tb_out_en;
  assign master_timebase_sel = st_ff.mtb_sel;
  assign resync_clock_output = st_ff.rs_wave;
  assign timebase_realign = st_ff.realign;
  assign frame_accepted_pulse = st_ff.fa_out;
  assign sampling_start = st_ff.start_pulse;
  assign sampling_started = st_ff.started;
  assign can_controller_run = (st_ff.task_cnt != 4'h0);

endmodule

// *** test/cstr_partner.sv ***
// partner model: other cards sharing the trigger bus
`timescale 1ns/100ps
module cstr_partner (
  input wire logic [6:0] trig_line_out,
  input wire logic [6:0] trig_line_oe,
  input wire logic resync_on,
  input wire logic star_req,
  output logic [6:0] trig_line_in,
  output logic star_trigger_input
);
  logic wave; // far-side resync wave, 800 ns period; we align on rises
  initial wave = 1'b1;
  // stands at the pull-up level while the far card is idle
  always #400 wave = resync_on ? ~wave : 1'b1;
  // wired lines: block drive wins, else far card, else pull-up
  assign trig_line_in = (trig_line_oe & trig_line_out) |
    (~trig_line_oe & {6'h3F, resync_on ? wave : 1'b1});
  // star trigger comes from the slot 2 card
  assign star_trigger_input = star_req;
endmodule

// *** test/cstr_routing_assertions.sv ***
// checker: timing relations at the crossbar ports
`timescale 1ns/100ps
module cstr_routing_assertions import cstr_pkg::*; #(
  parameter int RESYNC_HALF = CSTR_RESYNC_HALF_CYC,
  parameter int BIT_CYCLES = CSTR_BIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cstr_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [6:0] trig_line_oe,
  input wire logic rx_eof_last_bit,
  input wire logic rx_filter_pass,
  input wire logic timebase_line_oe,
  input wire logic [1:0] master_timebase_sel,
  input wire logic resync_clock_output,
  input wire logic timebase_realign,
  input wire logic frame_accepted_pulse,
  input wire logic sampling_start,
  input wire logic sampling_started,
  input wire logic can_controller_run
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] hi_ff; // cycles the frame pulse has stood
  logic [31:0] run_ff; // cycles the resync level has stood
  logic prev_ff; // resync level one sample back
  logic seen_ff; // first toggle passed, phase now known
  // helper counters; first half after reset is skipped on purpose
  always_ff @(posedge ref_clk) begin
    prev_ff <= resync_clock_output;
    if (rst) begin
      hi_ff <= 8'h00;
      run_ff <= 32'h0;
      seen_ff <= 1'b0;
    end else begin
      hi_ff <= frame_accepted_pulse ? hi_ff + 8'h01 : 8'h00;
      run_ff <= (resync_clock_output != prev_ff) ? 32'h1 : run_ff + 32'h1;
      seen_ff <= seen_ff | (resync_clock_output != prev_ff);
    end
  end
  sequence s_bad_route;
    bus_req.wr && bus_req.addr == CSTR_OFS_ROUTE && bus_req.wdata[8] &&
    bus_req.wdata[7:4] <= 4'h6 && bus_req.wdata[3:0] == CSTR_SRC_LOCAL_OSC;
  endsequence
  // oe lags the route table by a cycle, so only the second step is looked
  // at; a legal write just before may still settle in the first
  sequence s_oe_kept;
    ##1 $stable(trig_line_oe);
  endsequence
  property p_bad_route;
    s_bad_route |=> s_oe_kept;
  endproperty
  a_bad_route: assert property (p_bad_route)
    else $error("bad route moved");
  property p_frame_len;
    $fell(frame_accepted_pulse) |-> hi_ff == 8'(BIT_CYCLES);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame width");
  property p_frame_cause;
    $rose(frame_accepted_pulse) |-> $past(rx_eof_last_bit && rx_filter_pass);
  endproperty
  a_frame_cause: assert property (p_frame_cause)
    else $error("frame cause");
  property p_resync_half;
    seen_ff && $changed(resync_clock_output) |-> run_ff == RESYNC_HALF;
  endproperty
  a_resync_half: assert property (p_resync_half)
    else $error("resync duty");
  property p_rdata_idle;
    !$past(bus_req.rd) |-> bus_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("rdata idle");
  property p_teardown;
    $fell(can_controller_run) |-> ##[0:1] (trig_line_oe == 7'h00 &&
      !timebase_line_oe && master_timebase_sel == CSTR_MTB_LOCAL);
  endproperty
  a_teardown: assert property (p_teardown)
    else $error("teardown");
  property p_start_run;
    sampling_start |-> can_controller_run;
  endproperty
  a_start_run: assert property (p_start_run)
    else $error("start idle");
  property p_start_once;
    sampling_started && $past(sampling_started) |-> !sampling_start;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start twice");
  property p_realign;
    timebase_realign |=> !timebase_realign;
  endproperty
  a_realign: assert property (p_realign)
    else $error("realign width");
endmodule
bind cstr_routing cstr_routing_assertions #(.RESYNC_HALF(RESYNC_HALF),
  .BIT_CYCLES(BIT_CYCLES)) chk_u (.ref_clk(ref_clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .trig_line_oe(trig_line_oe),
  .rx_eof_last_bit(rx_eof_last_bit), .rx_filter_pass(rx_filter_pass),
  .timebase_line_oe(timebase_line_oe),
  .master_timebase_sel(master_timebase_sel),
  .resync_clock_output(resync_clock_output),
  .timebase_realign(timebase_realign),
  .frame_accepted_pulse(frame_accepted_pulse),
  .sampling_start(sampling_start), .sampling_started(sampling_started),
  .can_controller_run(can_controller_run));

// *** test/tb_top.sv ***
// testbench: register-driven routing scenarios for the crossbar
`timescale 1ns/100ps
module tb_top import cstr_pkg::*;;
  localparam int HALF = 4; // short resync half period
  localparam int BITC = 3; // short bit time
  logic ref_clk, rst, fault_n, eof, pass, resync_on, star_req, star;
  logic tb_oe, wave_out, realign, frame, sstart, started, run;
  cstr_bus_req_t req;
  logic [31:0] rdata, v;
  logic [6:0] l_in, l_out, l_oe;
  logic [1:0] mtb;
  int error_cnt, tests_run, cyc, n;
  cstr_routing #(.RESYNC_HALF(HALF), .BIT_CYCLES(BITC)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
    .trig_line_in(l_in), .trig_line_out(l_out), .trig_line_oe(l_oe),
    .star_trigger_input(star), .transceiver_fault_n(fault_n),
    .rx_eof_last_bit(eof), .rx_filter_pass(pass), .timebase_line_oe(tb_oe),
    .master_timebase_sel(mtb), .resync_clock_output(wave_out),
    .timebase_realign(realign), .frame_accepted_pulse(frame),
    .sampling_start(sstart), .sampling_started(started),
    .can_controller_run(run));
  cstr_partner part_u (.trig_line_out(l_out), .trig_line_oe(l_oe),
    .resync_on(resync_on), .star_req(star_req), .trig_line_in(l_in),
    .star_trigger_input(star));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // route write, then accept/refuse seen in the status error field
  task route(input logic [3:0] s, input logic [3:0] d, input logic ok);
    logic [31:0] st;
    wr(CSTR_OFS_ROUTE, {23'h0, 1'b1, d, s});
    rd(CSTR_OFS_STATUS, st);
    chk({31'h0, st[13:12] == CSTR_ERR_NONE}, {31'h0, ok});
  endtask
  // bounded wait for a one-cycle pulse: 0 start, 1 realign
  // looked at on each edge before it updates, so a pulse launched by the
  // edge that ended the caller's write is still caught
  task wait_on(input int sel, input int cnt);
    logic seen;
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge ref_clk);
      if ((sel == 0 ? sstart : realign) === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
  endtask
  // verdict, reached from the main sequence or the timeout
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    req = '0;
    rst = 1'b1;
    fault_n = 1'b1;
    eof = 1'b0;
    pass = 1'b0;
    resync_on = 1'b0;
    star_req = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CSTR_OFS_CONFIG, v);
    chk(v, 32'h80);
    rd(8'h20, v);
    chk(v, 32'h0);
    chk({30'h0, mtb}, {30'h0, CSTR_MTB_LOCAL});
    $display("test reset done");
    route(CSTR_SRC_RESYNC, 4'h2, 1'b1);
    route(CSTR_SRC_LOCAL_OSC, CSTR_DST_TB_LINE, 1'b1);
    chk({31'h0, tb_oe}, 32'h1);
    route(CSTR_SRC_LOCAL_OSC, 4'h3, 1'b0);
    chk({25'h0, l_oe}, 32'h04);
    route(CSTR_SRC_TB_LINE, 4'h2, 1'b0);
    route(CSTR_SRC_TB_LINE, CSTR_DST_MASTER_TB, 1'b1);
    chk({30'h0, mtb}, {30'h0, CSTR_MTB_TB_LINE});
    route(CSTR_SRC_BP10, CSTR_DST_MASTER_TB, 1'b0);
    chk({30'h0, mtb}, {30'h0, CSTR_MTB_TB_LINE});
    wr(CSTR_OFS_CONFIG, 32'hA3);
    route(CSTR_SRC_BP10, CSTR_DST_MASTER_TB, 1'b1);
    chk({30'h0, mtb}, {30'h0, CSTR_MTB_BP10});
    $display("test pairing done");
    for (n = 0; n < 7; n++) route(CSTR_SRC_FAULT, 4'(n), 1'b1);
    chk({25'h0, l_oe}, 32'h7F);
    @(posedge ref_clk);
    fault_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk({25'h0, l_out}, 32'h00);
    fault_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk({25'h0, l_out}, 32'h7F);
    $display("test lines done");
    wr(CSTR_OFS_CONFIG, 32'hA2);
    route(CSTR_SRC_STAR, CSTR_DST_START_SEL, 1'b0);
    wr(CSTR_OFS_CONFIG, 32'hA3);
    route(CSTR_SRC_STAR, CSTR_DST_START_SEL, 1'b1);
    route(CSTR_SRC_START, 4'h5, 1'b1);
    wr(CSTR_OFS_CONTROL, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk({31'h0, run}, 32'h1);
    chk({31'h0, started}, 32'h0);
    chk({31'h0, l_out[5]}, 32'h0);
    star_req <= 1'b1;
    wait_on(0, 8);
    chk({31'h0, l_out[5]}, 32'h1);
    wr(CSTR_OFS_CONTROL, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk({21'h0, run, tb_oe, mtb, l_oe}, 32'h0);
    wr(CSTR_OFS_CONTROL, 32'h1);
    wait_on(0, 4);
    chk({31'h0, started}, 32'h1);
    $display("test start done");
    @(posedge ref_clk);
    pass <= 1'b1;
    @(posedge ref_clk);
    eof <= 1'b1;
    @(posedge ref_clk);
    eof <= 1'b0;
    n = 0;
    repeat (BITC + 4) begin
      @(posedge ref_clk);
      if (frame === 1'b1) n++;
    end
    chk(32'(n), 32'(BITC));
    route(4'h0, CSTR_DST_RESYNC_IN, 1'b1);
    resync_on <= 1'b1;
    wait_on(1, 40);
    // free-running wave: one level change per half period
    n = 0;
    v[0] = wave_out;
    repeat (16) begin
      @(posedge ref_clk);
      if (wave_out !== v[0]) n++;
      v[0] = wave_out;
    end
    chk(32'(n), 32'(16 / HALF));
    // pcmcia board takes a timebase from the line, may not export one
    wr(CSTR_OFS_CONFIG, 32'hC0);
    route(CSTR_SRC_TB_LINE, CSTR_DST_MASTER_TB, 1'b1);
    chk({30'h0, mtb}, {30'h0, CSTR_MTB_TB_LINE});
    route(CSTR_SRC_LOCAL_OSC, CSTR_DST_TB_LINE, 1'b0);
    wr(CSTR_OFS_CONFIG, 32'h23);
    route(CSTR_SRC_TB_LINE, CSTR_DST_MASTER_TB, 1'b0);
    $display("test clocks done");
    summarize();
  end
endmodule
